//--- shared/srcal_pkg.sv
// constants for the automatic sysref alignment calibration block
package srcal_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] SRCAL_CTRL_OFF     = 12'h000;
  localparam logic [11:0] SRCAL_CFG_OFF      = 12'h004;
  localparam logic [11:0] SRCAL_TAD_OFF      = 12'h008;
  localparam logic [11:0] SRCAL_STAT_OFF     = 12'h00c;
  localparam logic [11:0] SRCAL_POS_LO_OFF   = 12'h02c;
  localparam logic [11:0] SRCAL_POS_MID_OFF  = 12'h030;
  localparam logic [11:0] SRCAL_POS_HI_OFF   = 12'h034;
  localparam logic [11:0] SRCAL_IRQ_STAT_OFF = 12'h038;
  localparam logic [11:0] SRCAL_IRQ_EN_OFF   = 12'h03c;
  localparam logic [11:0] SRCAL_IRQ_CLR_OFF  = 12'h040;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SRCAL_CTRL_EN_BIT    = 0;
  localparam int SRCAL_CTRL_SEL_LSB   = 8;
  localparam int SRCAL_APERTURE_DELAY_FINE_LSB   = 0;
  localparam int SRCAL_APERTURE_DELAY_COARSE_LSB = 8;
  localparam int SRCAL_APERTURE_CLOCK_INVERT_BIT    = 16;
  localparam int SRCAL_STAT_DONE_BIT  = 0;
  localparam int SRCAL_STAT_FOUND_BIT = 1;
  localparam int SRCAL_STAT_BUSY_BIT  = 2;
  localparam int SRCAL_STAT_RES_LSB   = 8;
  localparam int SRCAL_IRQ_DONE_BIT   = 0;
  localparam int SRCAL_IRQ_NOLOCK_BIT = 1;
  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int SRCAL_SEL_W   = 4;
  localparam int SRCAL_TAD_W   = 8;
  localparam int SRCAL_POS_W   = 24;
  localparam int SRCAL_IRQ_W   = 2;
  localparam logic [7:0] SRCAL_SETTLE_RST = 8'h10;
  typedef enum logic [1:0] {SRCAL_IDLE, SRCAL_SETTLE, SRCAL_CHECK} srcal_state_t;
endpackage : srcal_pkg

//--- sim/srcal_clkgen_model.sv
// clock source and edge detector model facing the calibration block
`timescale 1ns/1ps
module srcal_clkgen_model
  import srcal_pkg::*;
#(
  parameter logic [SRCAL_POS_W-1:0] POS_PATTERN = 24'h80_60_19
)(
  // bench controls
  input  wire logic                   lock_ok,
  input  wire logic [SRCAL_TAD_W-1:0] target_norm,
  input  wire logic [SRCAL_TAD_W-1:0] target_inv,
  // applied delay
  input  wire logic                   aperture_clock_invert,
  input  wire logic [SRCAL_TAD_W-1:0] aperture_delay_coarse,
  // detector results
  output logic                        sref_phase_hit,
  output logic      [SRCAL_POS_W-1:0] sref_position_status
);
  // periodic sysref, so the edge relation holds at every delay step
  assign sref_phase_hit = lock_ok &&
    (aperture_delay_coarse >= (aperture_clock_invert ? target_inv : target_norm));
  assign sref_position_status = POS_PATTERN;
endmodule : srcal_clkgen_model

//--- sim/srcal_top_bench.sv
// self-checking bench for the sysref calibration block
`timescale 1ns/1ps
module srcal_top_bench
  import srcal_pkg::*;
;
  localparam logic [23:0] POS = 24'h80_60_19;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hit, inv, irq, lock_ok, err, ei;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [7:0]  coarse, fine, t0, t1, ec;
  logic [3:0]  sel;
  logic [23:0] pos;
  logic [16:0] res_prev;
  int          n_mismatch, checks_done;
  logic [7:0]  tn [4] = '{8'h05, 8'h04, 8'h00, 8'h02};
  logic [7:0]  ti [4] = '{8'h03, 8'h04, 8'h09, 8'h01};
  logic        lk [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  srcal_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sref_phase_hit(hit),
    .sref_position_status(pos), .aperture_clock_invert(inv), .aperture_delay_coarse(coarse),
    .aperture_delay_fine(fine), .sref_sample_position_select(sel), .irq(irq));
  srcal_clkgen_model #(.POS_PATTERN(POS)) far (.lock_ok(lock_ok), .target_norm(t0), .target_inv(t1),
    .aperture_clock_invert(inv), .aperture_delay_coarse(coarse), .sref_phase_hit(hit), .sref_position_status(pos));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(d, exp);
  endtask : rd_chk

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, lock_ok, paddr, pwdata, t0, t1, res_prev} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(SRCAL_CFG_OFF, {24'h0, SRCAL_SETTLE_RST});
    rd_chk(SRCAL_STAT_OFF, 32'h0);
    rd_chk(SRCAL_TAD_OFF, 32'h0);
    rd_chk(SRCAL_IRQ_CLR_OFF, 32'h0);
    rd_chk(12'h100, 32'h0);
    check({31'h0, err}, 32'h1);
    rd_chk(SRCAL_POS_LO_OFF, {24'h0, POS[7:0]});
    rd_chk(SRCAL_POS_MID_OFF, {24'h0, POS[15:8]});
    rd_chk(SRCAL_POS_HI_OFF, {24'h0, POS[23:16]});
    $display("reset and map test done");
    xfer(1'b1, SRCAL_CFG_OFF, 32'h0);
    xfer(1'b1, SRCAL_IRQ_EN_OFF, 32'h3);
    for (int i = 0; i < 4; i++) begin
      lock_ok <= lk[i];
      t0 <= tn[i];
      t1 <= ti[i];
      ei = lk[i] && (ti[i] < tn[i]);
      ec = !lk[i] ? 8'h00 : ei ? ti[i] : tn[i];
      xfer(1'b1, SRCAL_CTRL_OFF, 32'h1);
      // the result field keeps the previous search until this one completes
      rd_chk(SRCAL_STAT_OFF, {7'h0, res_prev, 8'h04});
      repeat (600) if (d[0] !== 1'b1) xfer(1'b0, SRCAL_STAT_OFF, 32'h0);
      check(d, {7'h0, ei, ec, 8'h00, 6'h0, lk[i], 1'b1});
      check({15'h0, inv, coarse, fine}, {15'h0, ei, ec, 8'h00});
      check({31'h0, irq}, 32'h1);
      rd_chk(SRCAL_IRQ_STAT_OFF, {30'h0, !lk[i], 1'b1});
      xfer(1'b1, SRCAL_IRQ_CLR_OFF, 32'h3);
      rd_chk(SRCAL_IRQ_STAT_OFF, 32'h0);
      check({31'h0, irq}, 32'h0);
      res_prev = {ei, ec, 8'h00};
      $display("search case %0d done", i);
    end
    // mid-run reset, then a short search with the delay write refused while busy
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(SRCAL_STAT_OFF, 32'h0);
    lock_ok <= 1'b1;
    t0 <= 8'h00;
    t1 <= 8'h00;
    xfer(1'b1, SRCAL_CTRL_OFF, 32'h1);
    xfer(1'b1, SRCAL_TAD_OFF, 32'h1_05_07);
    repeat (600) if (d[0] !== 1'b1) xfer(1'b0, SRCAL_STAT_OFF, 32'h0);
    check(d, 32'h3);
    rd_chk(SRCAL_TAD_OFF, 32'h0);
    rd_chk(SRCAL_IRQ_STAT_OFF, 32'h1);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, SRCAL_IRQ_EN_OFF, 32'h1);
    @(negedge pclk);
    check({31'h0, irq}, 32'h1);
    $display("reset and mask test done");
    xfer(1'b1, SRCAL_CTRL_OFF, 32'h0);
    xfer(1'b1, SRCAL_TAD_OFF, 32'h1_05_07);
    @(negedge pclk);
    check({15'h0, inv, coarse, fine}, 32'h1_05_07);
    rd_chk(SRCAL_TAD_OFF, 32'h1_05_07);
    xfer(1'b1, SRCAL_CTRL_OFF, 32'hf00);
    @(negedge pclk);
    check({28'h0, sel}, 32'hf);
    xfer(1'b1, SRCAL_IRQ_EN_OFF, 32'h0);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    repeat (3) @(posedge pclk);
    $display("manual delay test done");
    stop_test();
  end
endmodule : srcal_top_bench

//--- sim/srcal_top_properties.sv
// concurrent checks on the ports of the sysref calibration block
`timescale 1ns/1ps
module srcal_top_properties
  import srcal_pkg::*;
(
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // status and controls
  input wire logic [SRCAL_POS_W-1:0] sref_position_status,
  input wire logic [SRCAL_SEL_W-1:0] sref_sample_position_select,
  input wire logic                   irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr inside {SRCAL_CTRL_OFF, SRCAL_CFG_OFF, SRCAL_TAD_OFF, SRCAL_STAT_OFF, SRCAL_POS_LO_OFF,
    SRCAL_POS_MID_OFF, SRCAL_POS_HI_OFF, SRCAL_IRQ_STAT_OFF, SRCAL_IRQ_EN_OFF, SRCAL_IRQ_CLR_OFF};
  wire setup_rd = psel && !penable && !pwrite;
  wire acc_wr   = psel && penable && pwrite;
  a_ready_always: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr) else $error("no error on unmapped");
  a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr) else $error("error on mapped");
  a_unmapped_zero: assert property (setup_rd && !mapped |=> prdata == 32'h0) else $error("unmapped data");
  a_clear_reads_zero: assert property (setup_rd && paddr == SRCAL_IRQ_CLR_OFF |=> prdata == 32'h0)
    else $error("clear register read nonzero");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
  a_pos_read: assert property (setup_rd && paddr == SRCAL_POS_LO_OFF |=>
    prdata == {24'h0, $past(sref_position_status[7:0])}) else $error("position status read wrong");
  a_sel_follow: assert property (acc_wr && paddr == SRCAL_CTRL_OFF |=>
    sref_sample_position_select == $past(pwdata[11:8])) else $error("select not applied");
  a_irq_mask: assert property (acc_wr && paddr == SRCAL_IRQ_EN_OFF && pwdata[1:0] == 2'h0 |=> !irq [*2])
    else $error("masked interrupt high");
endmodule : srcal_top_properties

bind srcal_top srcal_top_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sref_position_status(sref_position_status), .sref_sample_position_select(sref_sample_position_select),
  .irq(irq));

//--- verilog/srcal_top.sv
// automatic sysref alignment calibration with apb register file
//
// Overview of operation
// (RL1) host provides running clock, normal configuration first
// (RL2) clock source gives continuous periodic sysref
// (RL3) host writes config, then sets enable
// (RL4) enable steps delay until edges align
// (RL5) completion flag readable in status register
// (RL6) chosen delay readable in status result field
// (RL7) calibrated delay stays applied until overwritten
// (RL8) host may disable and adjust delay manually
// (RL9) host may restore stored delay at startup
// (RL10) no converter calibration during sysref calibration
// (RL11) background calibration off until completion flag
// (RL12) host sets sample position select to 0
// (RL13) search both polarities, keep smallest coarse
// (RL14) receiver picks elastic buffer release point
// (RL15) position status bit 1 means risky
// (RL16) select reaches only first 16 positions
// (RL17) completion clears on launch, else stays set
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module srcal_top
  import srcal_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // phase detector and sysref position detector
  input  wire logic                   sref_phase_hit,
  input  wire logic [SRCAL_POS_W-1:0] sref_position_status,
  // aperture delay and sysref sampling controls
  output logic                        aperture_clock_invert,
  output logic      [SRCAL_TAD_W-1:0] aperture_delay_coarse,
  output logic      [SRCAL_TAD_W-1:0] aperture_delay_fine,
  output logic      [SRCAL_SEL_W-1:0] sref_sample_position_select,
  // interrupt
  output logic                        irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    srcal_state_t           st;
    logic                   sref_cal_enable;
    logic [SRCAL_SEL_W-1:0] sel;
    logic [7:0]             sref_cal_config;
    logic                   inv;
    logic [SRCAL_TAD_W-1:0] coarse;
    logic [SRCAL_TAD_W-1:0] fine;
    logic                   aperture_cal_complete;
    logic                   found;
    logic                   best_inv;
    logic [SRCAL_TAD_W-1:0] best_coarse;
    logic [16:0]            result;
    logic [7:0]             cnt;
    logic [SRCAL_IRQ_W-1:0] irq_stat;
    logic [SRCAL_IRQ_W-1:0] irq_en;
    logic [31:0]            rdata;
  } srcal_regs_t;

  srcal_regs_t cur;
  srcal_regs_t next_cur;

  localparam logic [SRCAL_TAD_W-1:0] COARSE_MAX = '1;

  logic wr_acc;
  logic setup_rd;
  logic mapped;

  assign wr_acc   = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  always_comb begin
    case (paddr)
      SRCAL_CTRL_OFF, SRCAL_CFG_OFF, SRCAL_TAD_OFF, SRCAL_STAT_OFF,
      SRCAL_POS_LO_OFF, SRCAL_POS_MID_OFF, SRCAL_POS_HI_OFF,
      SRCAL_IRQ_STAT_OFF, SRCAL_IRQ_EN_OFF, SRCAL_IRQ_CLR_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [SRCAL_IRQ_W-1:0] irq_set;
    logic                   launch;
    logic                   busy;
    logic                   next_pol;
    irq_set  = '0;
    launch   = 1'b0;
    next_pol = 1'b0;
    next_cur = cur;
    busy     = (cur.st != SRCAL_IDLE);

    // register reads are captured in the setup phase
    if (setup_rd) begin
      next_cur.rdata = 32'h0000_0000;
      case (paddr)
        SRCAL_CTRL_OFF: begin
          next_cur.rdata[SRCAL_CTRL_EN_BIT] = cur.sref_cal_enable;
          next_cur.rdata[SRCAL_CTRL_SEL_LSB +: SRCAL_SEL_W] = cur.sel;
        end
        SRCAL_CFG_OFF: next_cur.rdata[7:0] = cur.sref_cal_config;
        SRCAL_TAD_OFF: begin
          next_cur.rdata[SRCAL_APERTURE_DELAY_FINE_LSB +: SRCAL_TAD_W]   = cur.fine;
          next_cur.rdata[SRCAL_APERTURE_DELAY_COARSE_LSB +: SRCAL_TAD_W] = cur.coarse;
          next_cur.rdata[SRCAL_APERTURE_CLOCK_INVERT_BIT]                   = cur.inv;
        end
        SRCAL_STAT_OFF: begin
          next_cur.rdata[SRCAL_STAT_DONE_BIT]  = cur.aperture_cal_complete; // see (RL5)
          next_cur.rdata[SRCAL_STAT_FOUND_BIT] = cur.found;
          next_cur.rdata[SRCAL_STAT_BUSY_BIT]  = busy;
          next_cur.rdata[SRCAL_STAT_RES_LSB +: 17] = cur.result; // see (RL6)
        end
        // 1 marks a risky position, passed straight from the detector
        SRCAL_POS_LO_OFF:   next_cur.rdata[7:0] = sref_position_status[7:0]; // see (RL15)
        SRCAL_POS_MID_OFF:  next_cur.rdata[7:0] = sref_position_status[15:8];
        SRCAL_POS_HI_OFF:   next_cur.rdata[7:0] = sref_position_status[23:16];
        SRCAL_IRQ_STAT_OFF: next_cur.rdata[SRCAL_IRQ_W-1:0] = cur.irq_stat;
        SRCAL_IRQ_EN_OFF:   next_cur.rdata[SRCAL_IRQ_W-1:0] = cur.irq_en;
        default:            next_cur.rdata = 32'h0000_0000;
      endcase
    end

    if (wr_acc) begin
      case (paddr)
        SRCAL_CTRL_OFF: begin
          next_cur.sref_cal_enable = pwdata[SRCAL_CTRL_EN_BIT];
          // only positions 0..15 can be chosen
          next_cur.sel = pwdata[SRCAL_CTRL_SEL_LSB +: SRCAL_SEL_W]; // see (RL16)
          launch = pwdata[SRCAL_CTRL_EN_BIT] && !busy; // see (RL4)
        end
        SRCAL_CFG_OFF: next_cur.sref_cal_config = pwdata[7:0];
        SRCAL_TAD_OFF: begin
          // manual override, ignored while a search owns the delay
          if (!busy) begin // see (RL8)
            next_cur.fine   = pwdata[SRCAL_APERTURE_DELAY_FINE_LSB +: SRCAL_TAD_W];
            next_cur.coarse = pwdata[SRCAL_APERTURE_DELAY_COARSE_LSB +: SRCAL_TAD_W];
            next_cur.inv    = pwdata[SRCAL_APERTURE_CLOCK_INVERT_BIT];
          end
        end
        SRCAL_IRQ_EN_OFF:  next_cur.irq_en   = pwdata[SRCAL_IRQ_W-1:0];
        SRCAL_IRQ_CLR_OFF: next_cur.irq_stat = cur.irq_stat & ~pwdata[SRCAL_IRQ_W-1:0];
        default: ;
      endcase
    end

    // ----------------------------------------
    // search engine
    // ----------------------------------------
    case (cur.st)
      SRCAL_IDLE: begin
        if (launch) begin
          next_cur.aperture_cal_complete = 1'b0; // see (RL17)
          next_cur.found  = 1'b0;
          next_cur.inv    = 1'b0;
          next_cur.coarse = '0;
          next_cur.fine   = '0;
          next_cur.cnt    = cur.sref_cal_config;
          next_cur.st     = SRCAL_SETTLE;
        end
      end
      SRCAL_SETTLE: begin
        if (cur.cnt == 8'h00) begin
          next_cur.st = SRCAL_CHECK;
        end else begin
          next_cur.cnt = cur.cnt - 8'h01;
        end
      end
      SRCAL_CHECK: begin
        if (sref_phase_hit) begin
          // first hit in a polarity is its smallest coarse step
          if (!cur.found || cur.coarse < cur.best_coarse) begin // see (RL13)
            next_cur.found       = 1'b1;
            next_cur.best_coarse = cur.coarse;
            next_cur.best_inv    = cur.inv;
          end
          next_pol = 1'b1;
        end else if (cur.coarse == COARSE_MAX) begin
          next_pol = 1'b1;
        end else begin
          next_cur.coarse = cur.coarse + 8'h01; // see (RL4)
          next_cur.cnt    = cur.sref_cal_config;
          next_cur.st     = SRCAL_SETTLE;
        end
        if (next_pol) begin
          if (!cur.inv) begin
            next_cur.inv    = 1'b1; // see (RL13)
            next_cur.coarse = '0;
            next_cur.cnt    = cur.sref_cal_config;
            next_cur.st     = SRCAL_SETTLE;
          end else begin
            // winner stays applied until the host writes the delay or launches a search
            next_cur.inv    = next_cur.found ? next_cur.best_inv : 1'b0; // see (RL7)
            next_cur.coarse = next_cur.found ? next_cur.best_coarse : '0;
            next_cur.result = {next_cur.inv, next_cur.coarse, cur.fine}; // see (RL6)
            next_cur.aperture_cal_complete = 1'b1; // see (RL5)
            irq_set[SRCAL_IRQ_DONE_BIT]   = 1'b1;
            irq_set[SRCAL_IRQ_NOLOCK_BIT] = !next_cur.found;
            next_cur.st = SRCAL_IDLE;
          end
        end
      end
      default: next_cur.st = SRCAL_IDLE;
    endcase

    // clearing enable mid-search abandons it
    if (busy && !next_cur.sref_cal_enable) begin
      next_cur.st = SRCAL_IDLE;
    end

    // a new event beats a clear in the same cycle
    next_cur.irq_stat = next_cur.irq_stat | irq_set;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur                 <= '0;
      cur.st              <= SRCAL_IDLE;
      cur.sref_cal_config <= SRCAL_SETTLE_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata                      = cur.rdata;
  assign aperture_clock_invert       = cur.inv;
  assign aperture_delay_coarse       = cur.coarse;
  assign aperture_delay_fine         = cur.fine;
  assign sref_sample_position_select = cur.sel;
  assign irq                         = |(cur.irq_stat & cur.irq_en);
endmodule : srcal_top
